// File: cmtf_framer.sv
/*
  Telemetry framer for the camera and its scan mirror controller: command
  register files, analog and digital replies, and the paced pixel stream.
  Assumes command bytes, transmit handshakes and pixels synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtf_framer
  import cmtf_pkg::*;
#(
  parameter int PIX_W = 12
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Camera command bytes
  input wire logic cam_cmd_valid_i,
  input wire logic [7:0] cam_cmd_byte_i,
  // Mirror command bytes
  input wire logic mir_cmd_valid_i,
  input wire logic [7:0] mir_cmd_byte_i,
  // Camera telemetry bytes
  output logic cam_tx_valid_o,
  output logic [7:0] cam_tx_byte_o,
  input wire logic cam_tx_ready_i,
  // Mirror telemetry bytes
  output logic mir_tx_valid_o,
  output logic [7:0] mir_tx_byte_o,
  input wire logic mir_tx_ready_i,
  // Analog converter
  output logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [11:0] adc_sample_i,
  // Camera status and control
  input wire logic fifo_full_i,
  input wire logic fifo_empty_i,
  input wire logic [2:0] wheel_pos_i,
  input wire logic [1:0] cam_exec_clr_i,
  output logic [1:0] cam_exec_o,
  output logic [11:0] exposure_count_o,
  output logic [2:0] analog_channel_index_o,
  output logic lamp_on_o,
  output logic compression_on_o,
  output logic bulb_open_o,
  output logic [2:0] wheel_step_count_o,
  // Mirror control
  output logic mir_vel_strobe_o,
  output logic [7:0] mirror_speed_value_o,
  output logic mirror_power_on_o,
  output logic mirror_heater_on_o,
  output logic mirror_rotation_dir_o,
  // Pixel stream
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  output logic pix_ready_o,
  output logic pix_out_valid_o,
  output logic [15:0] pix_word_o
);
  initial
  begin
    if (PIX_W != 12)
    begin
      $error("cmtf_framer serves 12-bit pixels only");
    end
  end

  // ****************************************
  // Camera registers
  // ****************************************
  logic ta, td, fn, en, ff_latch, bulb;
  logic [2:0] chan, wsteps;
  logic [11:0] exp_cnt;
  logic comp, lamp;
  logic ta_clr, td_clr;
  logic cam_wr, ex_wr;
  logic [2:0] cam_idx;
  logic [3:0] cam_d;

  assign cam_wr = cam_cmd_valid_i && !cam_cmd_byte_i[CMD_MARK_BIT];
  assign cam_idx = cam_cmd_byte_i[CMD_IDX_HI:CMD_IDX_LO];
  assign cam_d = cam_cmd_byte_i[3:0];
  assign ex_wr = cam_wr && (cam_idx == CAM_EXEC);

  // Zero bits in an execute write never cancel a busy request
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ta <= 1'b0;
      td <= 1'b0;
      fn <= 1'b0;
      en <= 1'b0;
    end
    else
    begin
      ta <= (ex_wr && cam_d[CAM_TA_BIT]) || (ta && !ta_clr);
      td <= (ex_wr && (cam_d[CAM_TD_BIT] || cam_d[CAM_EN_BIT])) || (td && !td_clr);
      fn <= (ex_wr && cam_d[CAM_FN_BIT]) || (fn && !cam_exec_clr_i[1]);
      en <= (ex_wr && cam_d[CAM_EN_BIT]) || (en && !cam_exec_clr_i[0]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      exp_cnt <= EXP_RST;
      chan <= 3'h0;
      comp <= 1'b0;
      lamp <= 1'b0;
      bulb <= 1'b0;
      wsteps <= 3'h0;
    end
    else if (cam_wr)
    begin
      unique case (cam_idx)
        CAM_EXP_LO: exp_cnt[3:0] <= cam_d;
        CAM_EXP_MID: exp_cnt[7:4] <= cam_d;
        CAM_EXP_HI: exp_cnt[11:8] <= cam_d;
        CAM_CHAN: chan <= cam_d[2:0];
        CAM_LAMP_COMP:
        begin
          comp <= cam_d[1];
          lamp <= cam_d[0];
        end
        CAM_BULB_WHEEL:
        begin
          bulb <= cam_d[3];
          wsteps <= cam_d[2:0];
        end
        CAM_EXEC, CAM_WHEEL_POS:
        begin
        end
      endcase
    end
  end

  // Full flag holds until a new exposure; a full in that cycle still sets
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ff_latch <= 1'b0;
    end
    else
    begin
      ff_latch <= fifo_full_i || (ff_latch && !(ex_wr && cam_d[CAM_EN_BIT]));
    end
  end

  assign cam_exec_o = {fn, en};
  assign exposure_count_o = exp_cnt;
  assign analog_channel_index_o = chan;
  assign lamp_on_o = lamp;
  assign compression_on_o = comp;
  assign bulb_open_o = bulb;
  assign wheel_step_count_o = wsteps;

  // ****************************************
  // Camera reply sequencer
  // ****************************************
  cmtf_state_t cst;
  logic [3:0] cbuf [8];
  logic [3:0] clen;
  logic [2:0] cidx;
  logic c_adv;

  assign c_adv = (cst == CMTF_SEND) && cam_tx_ready_i;
  assign ta_clr = (cst == CMTF_ADC) && adc_done_i;
  assign td_clr = (cst == CMTF_IDLE) && !ta && td;
  assign cam_tx_valid_o = (cst == CMTF_SEND);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cst <= CMTF_IDLE;
      clen <= 4'h0;
      cidx <= 3'h0;
      adc_start_o <= 1'b0;
      cam_tx_byte_o <= 8'h00;
      for (int i = 0; i < 8; i++)
      begin
        cbuf[i] <= NIB_RST;
      end
    end
    else
    begin
      adc_start_o <= 1'b0;
      unique case (cst)
        CMTF_IDLE:
        begin
          if (ta)
          begin
            adc_start_o <= 1'b1;
            cst <= CMTF_ADC;
          end
          else if (td)
          begin
            // Snapshot taken at once so the dump is self-consistent
            cbuf[0] <= {1'b0, 1'b1, fn, en};
            cbuf[1] <= exp_cnt[3:0];
            cbuf[2] <= exp_cnt[7:4];
            cbuf[3] <= exp_cnt[11:8];
            cbuf[4] <= {1'b0, chan};
            cbuf[5] <= {ff_latch, fifo_empty_i, comp, lamp};
            cbuf[6] <= {bulb, wsteps};
            cbuf[7] <= {^wheel_pos_i, wheel_pos_i};
            cam_tx_byte_o <= {TX_MARK, 3'h0, 1'b0, 1'b1, fn, en};
            clen <= CAM_DUMP_LEN;
            cidx <= 3'h0;
            cst <= CMTF_SEND;
          end
        end
        CMTF_ADC:
        begin
          if (adc_done_i)
          begin
            cbuf[1] <= adc_sample_i[3:0];
            cbuf[2] <= adc_sample_i[7:4];
            cbuf[3] <= adc_sample_i[11:8];
            cam_tx_byte_o <= {TX_MARK, 3'h0, ANA_CHAN_MARK, chan};
            clen <= ANA_LEN;
            cidx <= 3'h0;
            cst <= CMTF_SEND;
          end
        end
        CMTF_SEND:
        begin
          if (c_adv)
          begin
            if ({1'b0, cidx} == clen - 4'h1)
            begin
              cst <= CMTF_IDLE;
            end
            else
            begin
              cidx <= cidx + 3'h1;
              cam_tx_byte_o <= {TX_MARK, cidx + 3'h1, cbuf[cidx + 3'h1]};
            end
          end
        end
        default: cst <= CMTF_IDLE;
      endcase
    end
  end

  // ****************************************
  // Mirror registers and reply
  // ****************************************
  logic mtd, mvn, mpow, mheat, mdir, msend;
  logic [7:0] mvel;
  logic [3:0] mbuf [4];
  logic [1:0] midx;
  logic mir_wr;
  logic [2:0] mir_idx;
  logic [3:0] mir_d;

  assign mir_wr = mir_cmd_valid_i && !mir_cmd_byte_i[CMD_MARK_BIT];
  assign mir_idx = mir_cmd_byte_i[CMD_IDX_HI:CMD_IDX_LO];
  assign mir_d = mir_cmd_byte_i[3:0];
  assign mir_tx_valid_o = msend;
  assign mirror_power_on_o = mpow;
  assign mirror_heater_on_o = mheat;
  assign mirror_rotation_dir_o = mdir;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mvn <= 1'b0;
      mvel <= VEL_RST;
      mpow <= 1'b0;
      mheat <= 1'b0;
      mdir <= 1'b0;
      mir_vel_strobe_o <= 1'b0;
      mirror_speed_value_o <= VEL_RST;
    end
    else
    begin
      // Velocity strobed out the cycle after the request, then cleared
      mir_vel_strobe_o <= mvn;
      if (mvn)
      begin
        mirror_speed_value_o <= mvel;
      end
      mvn <= mir_wr && (mir_idx == MIR_EXEC) && mir_d[MIR_VN_BIT];
      if (mir_wr && (mir_idx == MIR_VEL_LO))
      begin
        mvel[3:0] <= mir_d;
      end
      if (mir_wr && (mir_idx == MIR_VEL_HI))
      begin
        mvel[7:4] <= mir_d;
      end
      if (mir_wr && (mir_idx == MIR_MOTOR))
      begin
        mpow <= mir_d[2];
        mheat <= mir_d[1];
        mdir <= mir_d[0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mtd <= 1'b0;
      msend <= 1'b0;
      midx <= 2'h0;
      mir_tx_byte_o <= 8'h00;
      for (int i = 0; i < 4; i++)
      begin
        mbuf[i] <= NIB_RST;
      end
    end
    else
    begin
      mtd <= (mir_wr && (mir_idx == MIR_EXEC) && mir_d[MIR_TD_BIT]) || (mtd && msend);
      if (!msend && mtd)
      begin
        mbuf[1] <= mvel[3:0];
        mbuf[2] <= mvel[7:4];
        mbuf[3] <= {1'b0, mpow, mheat, mdir};
        mir_tx_byte_o <= {TX_MARK, 3'h0, 1'b0, 1'b1, 1'b0, mvn};
        midx <= 2'h0;
        msend <= 1'b1;
      end
      else if (msend && mir_tx_ready_i)
      begin
        if ({2'b00, midx} == MIR_DUMP_LEN - 4'h1)
        begin
          msend <= 1'b0;
        end
        else
        begin
          midx <= midx + 2'h1;
          mir_tx_byte_o <= {TX_MARK, 1'b0, midx + 2'h1, mbuf[midx + 2'h1]};
        end
      end
    end
  end

  // ****************************************
  // Pixel pacing and compression
  // ****************************************
  logic [PIX_CNT_W-1:0] pcnt;
  logic [7:0] sq;
  logic [PIX_W-1:0] praw;
  logic pv1;

  assign pix_ready_o = (pcnt == PIX_CNT_W'(PIX_PERIOD_CYC - 1));

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pcnt <= '0;
    end
    else
    begin
      pcnt <= pix_ready_o ? '0 : pcnt + PIX_CNT_W'(1);
    end
  end

  cmtf_sqrt_rom #(
    .IN_W(PIX_W)
  ) u_rom (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .addr_i(pix_data_i),
    .data_o(sq)
  );

  // Mode sampled at output so a switch mid-frame takes effect per pixel
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pv1 <= 1'b0;
      praw <= '0;
      pix_out_valid_o <= 1'b0;
      pix_word_o <= PIX_WORD_RST;
    end
    else
    begin
      pv1 <= pix_ready_o && pix_valid_i;
      praw <= pix_data_i;
      pix_out_valid_o <= pv1;
      if (pv1)
      begin
        pix_word_o <= comp ? {8'h00, sq} : {4'h0, praw};
      end
    end
  end
endmodule
`default_nettype wire

// File: cmtf_pkg.sv
/*
  Constants shared by the telemetry framer, and the square-root lookup used
  for pixel compression.
  Assumes a single 20 MHz clock and an active-low asynchronous reset.
*/
// ****************************************
// Package
// ****************************************
package cmtf_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int PIX_RATE_HZ = 300000;
  // Period rounded up so the pixel rate is never exceeded
  localparam int PIX_PERIOD_CYC = (CLK_HZ + PIX_RATE_HZ - 1) / PIX_RATE_HZ;
  localparam int PIX_CNT_W = $clog2(PIX_PERIOD_CYC);
  // Command byte layout
  localparam int CMD_MARK_BIT = 7;
  localparam int CMD_IDX_HI = 6;
  localparam int CMD_IDX_LO = 4;
  // Camera register indices
  localparam logic [2:0] CAM_EXEC = 3'h0;
  localparam logic [2:0] CAM_EXP_LO = 3'h1;
  localparam logic [2:0] CAM_EXP_MID = 3'h2;
  localparam logic [2:0] CAM_EXP_HI = 3'h3;
  localparam logic [2:0] CAM_CHAN = 3'h4;
  localparam logic [2:0] CAM_LAMP_COMP = 3'h5;
  localparam logic [2:0] CAM_BULB_WHEEL = 3'h6;
  localparam logic [2:0] CAM_WHEEL_POS = 3'h7;
  // Mirror register indices
  localparam logic [2:0] MIR_EXEC = 3'h0;
  localparam logic [2:0] MIR_VEL_LO = 3'h1;
  localparam logic [2:0] MIR_VEL_HI = 3'h2;
  localparam logic [2:0] MIR_MOTOR = 3'h3;
  // Execute register bit positions
  localparam int CAM_TA_BIT = 3;
  localparam int CAM_TD_BIT = 2;
  localparam int CAM_FN_BIT = 1;
  localparam int CAM_EN_BIT = 0;
  localparam int MIR_TD_BIT = 2;
  localparam int MIR_VN_BIT = 0;
  // Reply lengths and headers
  localparam logic [3:0] ANA_LEN = 4'h4;
  localparam logic [3:0] CAM_DUMP_LEN = 4'h8;
  localparam logic [3:0] MIR_DUMP_LEN = 4'h4;
  localparam logic ANA_CHAN_MARK = 1'b1;
  localparam logic TX_MARK = 1'b1;
  // Reset values
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [11:0] EXP_RST = 12'h000;
  localparam logic [7:0] VEL_RST = 8'h00;
  localparam logic [15:0] PIX_WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    CMTF_IDLE = 2'b00,
    CMTF_ADC = 2'b01,
    CMTF_SEND = 2'b10
  } cmtf_state_t;

  typedef logic [7:0] cmtf_lut_t [4096];

  function automatic cmtf_lut_t cmtf_build_lut();
    cmtf_lut_t lut;
    logic [15:0] v;
    logic [7:0] r;
    logic [7:0] t;
    for (int x = 0; x < 4096; x++)
    begin
      v = 16'(x) << 4;
      r = 8'h00;
      for (int b = 7; b >= 0; b--)
      begin
        t = r | (8'h01 << b);
        if ((16'(t) * 16'(t)) <= v)
        begin
          r = t;
        end
      end
      lut[x] = r;
    end
    return lut;
  endfunction
endpackage

`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Square-root compression table
// ****************************************
module cmtf_sqrt_rom
  import cmtf_pkg::*;
#(
  parameter int IN_W = 12
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Lookup
  input wire logic [IN_W-1:0] addr_i,
  output logic [7:0] data_o
);
  localparam cmtf_lut_t LUT = cmtf_build_lut();

  initial
  begin
    if (IN_W != 12)
    begin
      $error("cmtf_sqrt_rom serves 12-bit pixels only");
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      data_o <= 8'h00;
    end
    else
    begin
      data_o <= LUT[addr_i];
    end
  end
endmodule
`default_nettype wire

// File: cmtf_chk.sv
/*
  Port-level checker for the telemetry framer.
  Assumes binding to cmtf_framer with its reset active low.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtf_chk
  import cmtf_pkg::*;
#(
  parameter int PIX_W = 12
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Replies
  input wire logic cam_cmd_valid_i,
  input wire logic [7:0] cam_cmd_byte_i,
  input wire logic cam_tx_valid_o,
  input wire logic [7:0] cam_tx_byte_o,
  input wire logic cam_tx_ready_i,
  input wire logic mir_tx_valid_o,
  input wire logic [7:0] mir_tx_byte_o,
  input wire logic mir_tx_ready_i,
  input wire logic adc_start_o,
  input wire logic adc_done_i,
  input wire logic [2:0] analog_channel_index_o,
  // Pixels
  input wire logic compression_on_o,
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic pix_ready_o,
  input wire logic pix_out_valid_o,
  input wire logic [15:0] pix_word_o
);
  // ****************************************
  // Helpers
  // ****************************************
  logic [7:0] gap;
  logic seen;
  logic [2:0] cam_nxt;
  logic [2:0] mir_nxt;
  assign cam_nxt = cam_tx_byte_o[6:4] + 3'h1;
  assign mir_nxt = mir_tx_byte_o[6:4] + 3'h1;
  // Cycles since the last pixel slot
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gap <= 8'h00;
      seen <= 1'b0;
    end
    else
    begin
      gap <= pix_ready_o ? 8'h00 : gap + 8'h01;
      seen <= seen | pix_ready_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****************************************
  // Properties
  // ****************************************
  property p_cam_mark; cam_tx_valid_o |-> cam_tx_byte_o[7]; endproperty
  a_cam_mark: assert property (p_cam_mark) else $error("camera byte bit 7 low");
  property p_mir_mark; mir_tx_valid_o |-> mir_tx_byte_o[7]; endproperty
  a_mir_mark: assert property (p_mir_mark) else $error("mirror byte bit 7 low");
  property p_hold; cam_tx_valid_o && !cam_tx_ready_i |=> cam_tx_valid_o && $stable(cam_tx_byte_o); endproperty
  a_hold: assert property (p_hold) else $error("camera byte dropped while stalled");
  property p_cam_asc;
    cam_tx_valid_o && cam_tx_ready_i && cam_tx_byte_o[6:4] != 3'h3 && cam_tx_byte_o[6:4] != 3'h7
    |=> cam_tx_valid_o && cam_tx_byte_o[6:4] == $past(cam_nxt);
  endproperty
  a_cam_asc: assert property (p_cam_asc) else $error("camera reply not ascending");
  property p_mir_asc;
    mir_tx_valid_o && mir_tx_ready_i && mir_tx_byte_o[6:4] < 3'h3
    |=> mir_tx_valid_o && mir_tx_byte_o[6:4] == $past(mir_nxt);
  endproperty
  a_mir_asc: assert property (p_mir_asc) else $error("mirror reply not ascending");
  property p_chan; adc_done_i |=> cam_tx_valid_o && cam_tx_byte_o == {5'h11, analog_channel_index_o}; endproperty
  a_chan: assert property (p_chan) else $error("channel echo byte wrong");
  property p_req; cam_cmd_valid_i && cam_cmd_byte_i == 8'h08 && !cam_tx_valid_o |-> ##2 adc_start_o; endproperty
  a_req: assert property (p_req) else $error("analog request did not start sampling");
  property p_pace; pix_ready_o && seen |-> gap == 8'(PIX_PERIOD_CYC - 1); endproperty
  a_pace: assert property (p_pace) else $error("pixel slot spacing wrong");
  property p_raw;
    pix_ready_o && pix_valid_i && !compression_on_o ##1 !compression_on_o
    |=> pix_out_valid_o && pix_word_o == {4'h0, $past(pix_data_i, 2)};
  endproperty
  a_raw: assert property (p_raw) else $error("raw pixel word wrong");
  c_analog: cover property (adc_done_i);
  c_stall: cover property (cam_tx_valid_o && !cam_tx_ready_i);
  c_mir: cover property (mir_tx_valid_o && mir_tx_ready_i);
  c_comp: cover property (pix_out_valid_o && compression_on_o);
endmodule
`default_nettype wire

// File: cmtf_host.sv
/*
  Flight computer model: accepts telemetry bytes and logs them.
  Assumes the bench reads the logs in the order of its own requests.
*/
`timescale 1ns/1ps
`default_nettype none
module cmtf_host
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Pace control
  input wire logic slow_i,
  // Telemetry links
  input wire logic cam_valid_i,
  input wire logic [7:0] cam_byte_i,
  output logic cam_ready_o,
  input wire logic mir_valid_i,
  input wire logic [7:0] mir_byte_i,
  output logic mir_ready_o
);
  logic [7:0] cam_log [64];
  logic [7:0] mir_log [64];
  int cam_n;
  int mir_n;
  logic tog;
  // Slow mode takes a byte every other cycle
  assign cam_ready_o = !slow_i || tog;
  assign mir_ready_o = !slow_i || !tog;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tog <= 1'b0;
      cam_n <= 0;
      mir_n <= 0;
    end
    else
    begin
      tog <= ~tog;
      // Reply kind is known only from request order
      if (cam_valid_i && cam_ready_o)
      begin
        cam_log[cam_n[5:0]] <= cam_byte_i;
        cam_n <= cam_n + 1;
      end
      if (mir_valid_i && mir_ready_o)
      begin
        mir_log[mir_n[5:0]] <= mir_byte_i;
        mir_n <= mir_n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: cmtf_tb.sv
/*
  Self-checking bench for the telemetry framer.
  Assumes the checker and the flight computer model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PIX_W = 12;
  logic clk, rst_n, cv, mv, slow, cr, mr, ctv, mtv, ast, adn, pv, prdy, pov, vstb, fe;
  logic [7:0] cb, mb, ctb, mtb, spd;
  logic [11:0] smp, pd, expo;
  logic [15:0] pw;
  logic [2:0] wp;
  logic ff, lmp, cmp, blb, mpw, mht, mdr;
  logic [1:0] clr, cex;
  logic [2:0] chn, wst;
  int failures, n_compared;

  cmtf_framer #(.PIX_W(PIX_W)) dut (.clk_i(clk), .arst_n_i(rst_n), .cam_cmd_valid_i(cv), .cam_cmd_byte_i(cb),
    .mir_cmd_valid_i(mv), .mir_cmd_byte_i(mb), .cam_tx_valid_o(ctv), .cam_tx_byte_o(ctb), .cam_tx_ready_i(cr),
    .mir_tx_valid_o(mtv), .mir_tx_byte_o(mtb), .mir_tx_ready_i(mr), .adc_start_o(ast), .adc_done_i(adn),
    .adc_sample_i(smp), .fifo_full_i(ff), .fifo_empty_i(fe), .wheel_pos_i(wp), .cam_exec_clr_i(clr),
    .cam_exec_o(cex), .exposure_count_o(expo), .analog_channel_index_o(chn), .lamp_on_o(lmp),
    .compression_on_o(cmp), .bulb_open_o(blb), .wheel_step_count_o(wst), .mir_vel_strobe_o(vstb),
    .mirror_speed_value_o(spd), .mirror_power_on_o(mpw), .mirror_heater_on_o(mht),
    .mirror_rotation_dir_o(mdr), .pix_valid_i(pv),
    .pix_data_i(pd), .pix_ready_o(prdy), .pix_out_valid_o(pov), .pix_word_o(pw));
  cmtf_host host (.clk_i(clk), .arst_n_i(rst_n), .slow_i(slow), .cam_valid_i(ctv), .cam_byte_i(ctb),
    .cam_ready_o(cr), .mir_valid_i(mtv), .mir_byte_i(mtb), .mir_ready_o(mr));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic cam, input logic [7:0] b);
    @(posedge clk);
    cv <= cam;
    mv <= !cam;
    cb <= b;
    mb <= b;
    @(posedge clk);
    cv <= 1'b0;
    mv <= 1'b0;
  endtask

  task automatic collect(input logic cam, input int k, output logic [63:0] got);
    int base;
    base = cam ? host.cam_n : host.mir_n;
    got = '0;
    for (int w = 0; w < 400 && (cam ? host.cam_n : host.mir_n) < base + k; w++)
      @(negedge clk);
    for (int i = 0; i < k; i++)
      got = {got[55:0], cam ? host.cam_log[(base + i) % 64] : host.mir_log[(base + i) % 64]};
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_analog(input logic [2:0] ch, input logic [11:0] s, input logic sl, input logic [31:0] e);
    logic [63:0] got;
    slow <= sl;
    wr(1'b1, {4'h4, 1'b0, ch});
    wr(1'b1, 8'h08);
    for (int w = 0; w < 20 && !ast; w++)
      @(negedge clk);
    @(posedge clk);
    adn <= 1'b1;
    smp <= s;
    @(posedge clk);
    adn <= 1'b0;
    collect(1'b1, 4, got);
    chk(got, {32'h0, e});
  endtask

  task automatic t_expose();
    logic [63:0] got;
    // Exposure write also requests a dump
    wr(1'b1, 8'h01);
    collect(1'b1, 8, got);
    chk(got, 64'h8590A0B0C7D4E0F5);
    wr(1'b1, 8'h02);
    @(negedge clk);
    chk({62'h0, cex}, 64'h3);
    @(posedge clk);
    clr <= 2'h3;
    @(posedge clk);
    clr <= 2'h0;
    @(negedge clk);
    chk({62'h0, cex}, 64'h0);
  endtask

  task automatic t_dump();
    logic [63:0] got;
    // Refused and read-only writes sit between real ones
    wr(1'b1, 8'h15);
    wr(1'b1, 8'h2A);
    wr(1'b1, 8'h3C);
    wr(1'b1, 8'h45);
    wr(1'b1, 8'hC0);
    wr(1'b1, 8'h5F);
    wr(1'b1, 8'h6B);
    wr(1'b1, 8'h70);
    // Full pulse is latched and shows in the dump
    @(posedge clk);
    ff <= 1'b1;
    @(posedge clk);
    ff <= 1'b0;
    wr(1'b1, 8'h04);
    collect(1'b1, 8, got);
    chk(got, 64'h8495AABCC5DFEBF5);
    chk({55'h0, blb, wst, lmp, cmp, chn}, 64'h17D);
    chk({52'h0, expo}, 64'hCA5);
  endtask

  task automatic t_mirror();
    logic [63:0] got;
    wr(1'b0, 8'h1A);
    wr(1'b0, 8'h25);
    wr(1'b0, 8'h35);
    wr(1'b0, 8'h01);
    for (int w = 0; w < 20 && !vstb; w++)
      @(negedge clk);
    chk({56'h0, spd}, 64'h5A);
    chk({61'h0, mpw, mht, mdr}, 64'h5);
    wr(1'b0, 8'h04);
    collect(1'b0, 4, got);
    chk(got, 64'h849AA5B5);
  endtask

  task automatic t_pixel(input logic c, input logic [11:0] d, input logic [15:0] e);
    wr(1'b1, {4'h5, 2'h0, c, 1'b0});
    @(posedge clk);
    pv <= 1'b1;
    pd <= d;
    // Ready is combinational; look at it only once settled
    @(negedge clk);
    for (int w = 0; w < 100 && !prdy; w++)
      @(negedge clk);
    @(posedge clk);
    pv <= 1'b0;
    for (int w = 0; w < 10 && !pov; w++)
      @(negedge clk);
    chk({48'h0, pw}, {48'h0, e});
  endtask

  initial
  begin
    {cv, mv, slow, adn, pv, ff} = 6'h00;
    clr = 2'h0;
    {cb, mb, smp, pd} = '0;
    fe = 1'b1;
    wp = 3'h5;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_analog(3'h5, 12'h9C3, 1'b0, 32'h8D93ACB9);
    t_analog(3'h7, 12'h0F0, 1'b1, 32'h8F90AFB0);
    t_expose();
    t_dump();
    t_mirror();
    slow <= 1'b0;
    t_pixel(1'b0, 12'h009, 16'h0009);
    t_pixel(1'b0, 12'hFFF, 16'h0FFF);
    t_pixel(1'b1, 12'h009, 16'h000C);
    t_pixel(1'b1, 12'hFFF, 16'h00FF);
    test_done();
  end

  // Whole run is a few hundred cycles
  initial
  begin
    #1000000;
    failures++;
    test_done();
  end
endmodule

bind cmtf_framer cmtf_chk #(.PIX_W(PIX_W)) u_chk (.clk_i, .arst_n_i, .cam_cmd_valid_i, .cam_cmd_byte_i,
  .cam_tx_valid_o, .cam_tx_byte_o, .cam_tx_ready_i, .mir_tx_valid_o, .mir_tx_byte_o, .mir_tx_ready_i,
  .adc_start_o, .adc_done_i, .analog_channel_index_o, .compression_on_o, .pix_valid_i, .pix_data_i,
  .pix_ready_o, .pix_out_valid_o, .pix_word_o);
`default_nettype wire
